// ===== eif_defines.svh
`ifndef EIF_DEFINES_SVH
`define EIF_DEFINES_SVH

// ==========================================================
// Register indices (byte address = index * 4)
`define EIF_IDX_CTRL2 12'hfd9
`define EIF_IDX_CTRL3 12'hfda
`define EIF_IDX_STATUS 12'hfdb
`define EIF_IDX_ENABLE 12'hfdc
`define EIF_IDX_CLEAR 12'hfdd

// ==========================================================
// Control register fields
`define EIF_RATE_LSB 0
`define EIF_ES_LSB 2
`define EIF_LVL_BIT 4
`define EIF_CTRL_RST 8'h00
`define EIF_IRQ_RST 2'h0

// ==========================================================
// Filter timing
`define EIF_LF_DIV_LAST 2'h3
`define EIF_MASK_DIV1 4'h0
`define EIF_MASK_DIV4 4'h3
`define EIF_MASK_DIV8 4'h7
`define EIF_MASK_DIV16 4'hf

`endif

// ===== eif_pkg.sv
package eif_pkg;

  // ==========================================================
  // Field encodings
  typedef enum logic [1:0] {
    EIF_ES_RISE = 2'h0,
    EIF_ES_FALL = 2'h1,
    EIF_ES_BOTH = 2'h2,
    EIF_ES_RSVD = 2'h3
  } eif_edge_t;

  typedef enum logic [1:0] {
    EIF_RATE_DIV1 = 2'h0,
    EIF_RATE_DIV4 = 2'h1,
    EIF_RATE_DIV8 = 2'h2,
    EIF_RATE_DIV16 = 2'h3
  } eif_rate_t;

  typedef enum logic [1:0] {
    EIF_BUS_IDLE = 2'b01,
    EIF_BUS_ACK = 2'b10
  } eif_bus_t;

  // ==========================================================
  // State records
  typedef struct packed {
    logic [2:0] sync;
    logic qual;
    logic [3:0] pre;
    logic [1:0] lf_div;
    logic [1:0] hist;
    logic filt;
    logic req;
    logic lvl;
  } eif_chan_st_t;

  typedef struct packed {
    eif_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    eif_edge_t [1:0] es;
    eif_rate_t [1:0] rate;
    logic [1:0] status;
    logic [1:0] enable;
    logic irq;
  } eif_top_st_t;

endpackage : eif_pkg

// ===== eif_chan.sv
`timescale 1ns/1ps
`include "eif_defines.svh"

module eif_chan (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic gear_tick,
  input wire logic low_freq_tick,
  input wire logic low_speed,
  input wire eif_pkg::eif_edge_t edge_sel,
  input wire eif_pkg::eif_rate_t filter_rate,
  output logic req,
  output logic level,
  output logic filtered
);
  import eif_pkg::*;

  eif_chan_st_t st_ff;
  eif_chan_st_t nxt_st;

  // ==========================================================
  // Sync, sample clock, noise filter, edge detect
  always_comb begin
    logic tick;
    logic fire;
    logic [3:0] mask;
    tick = 1'b0;
    fire = 1'b0;
    mask = `EIF_MASK_DIV1;
    nxt_st = st_ff;
    nxt_st.req = 1'b0;
    nxt_st.sync = {st_ff.sync[1:0], pin};
    // Change counts once second and third stage agree
    if (st_ff.sync[2] == st_ff.sync[1]) begin
      nxt_st.qual = st_ff.sync[2];
    end
    unique case (filter_rate)
      EIF_RATE_DIV1: mask = `EIF_MASK_DIV1;
      EIF_RATE_DIV4: mask = `EIF_MASK_DIV4;
      EIF_RATE_DIV8: mask = `EIF_MASK_DIV8;
      EIF_RATE_DIV16: mask = `EIF_MASK_DIV16;
    endcase
    if (low_speed) begin
      if (low_freq_tick) begin
        nxt_st.lf_div = st_ff.lf_div + 2'h1;
        tick = (st_ff.lf_div == `EIF_LF_DIV_LAST);
      end
    end else if (gear_tick) begin
      nxt_st.pre = st_ff.pre + 4'h1;
      tick = ((st_ff.pre & mask) == 4'h0);
    end
    if (tick) begin
      nxt_st.hist = {st_ff.hist[0], st_ff.qual};
      // Three equal samples move the filtered level
      if (st_ff.hist == {2{st_ff.qual}} && st_ff.qual != st_ff.filt) begin
        nxt_st.filt = st_ff.qual;
        unique case (edge_sel)
          EIF_ES_RISE: fire = st_ff.qual;
          EIF_ES_FALL: fire = ~st_ff.qual;
          EIF_ES_BOTH: fire = 1'b1;
          EIF_ES_RSVD: fire = 1'b0;
        endcase
      end
    end
    if (fire) begin
      nxt_st.req = 1'b1;
      nxt_st.lvl = st_ff.qual;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign req = st_ff.req;
  assign level = st_ff.lvl;
  assign filtered = st_ff.filt;

endmodule : eif_chan

// ===== eif_ctrl.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "eif_defines.svh"

// What this block does
// - Edge code 00 requests on a rising filtered edge and code 01 on a falling one.
// - Edge code 10 requests on both filtered edges and the reserved code 11 requests nothing.
// - At high speed the filter samples at the gear rate divided by 1, 4, 8 or 16 per the rate field.
// - At low speed the filter samples at a quarter of the low-frequency clock whatever the rate field.
// - Each request stores the filtered level, 0 for initial or low and 1 for high.
// - The level bit is read-only, the edge and rate fields read/write, and all clear to zero on reset.
// - Bits 7 to 5 of each control register read as zero.
// - Channel 2 control sits at index 0x0fd9 and channel 3 at 0x0fda.
// - The level bit is refreshed on every request of its channel.
module eif_ctrl (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic [13:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_IRQ2_PIN,
  input wire logic EXT_IRQ3_PIN,
  input wire logic GEAR_TICK,
  input wire logic LOW_FREQ_TICK,
  input wire logic LOW_SPEED_MODE,
  output logic IRQ2_REQ,
  output logic IRQ3_REQ,
  output logic IRQ
);
  import eif_pkg::*;

  localparam int NCH = 2;

  eif_top_st_t st_ff;
  eif_top_st_t nxt_st;

  logic [NCH-1:0] ch_req;
  logic [NCH-1:0] ch_lvl;
  logic [NCH-1:0] ch_pin;

  assign ch_pin = {EXT_IRQ3_PIN, EXT_IRQ2_PIN};

  // ==========================================================
  // Channels 2 and 3
  eif_chan u_ch2 (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .pin(ch_pin[0]),
    .gear_tick(GEAR_TICK),
    .low_freq_tick(LOW_FREQ_TICK),
    .low_speed(LOW_SPEED_MODE),
    .edge_sel(st_ff.es[0]),
    .filter_rate(st_ff.rate[0]),
    .req(ch_req[0]),
    .level(ch_lvl[0]),
    .filtered()
  );

  eif_chan u_ch3 (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .pin(ch_pin[1]),
    .gear_tick(GEAR_TICK),
    .low_freq_tick(LOW_FREQ_TICK),
    .low_speed(LOW_SPEED_MODE),
    .edge_sel(st_ff.es[1]),
    .filter_rate(st_ff.rate[1]),
    .req(ch_req[1]),
    .level(ch_lvl[1]),
    .filtered()
  );

  // ==========================================================
  // Register read mux
  function automatic logic [31:0] eif_read(
    input eif_top_st_t s,
    input logic [NCH-1:0] lvl,
    input logic [11:0] idx
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx == `EIF_IDX_CTRL2) begin
      d[`EIF_LVL_BIT] = lvl[0];
      d[`EIF_ES_LSB +: 2] = s.es[0];
      d[`EIF_RATE_LSB +: 2] = s.rate[0];
    end else if (idx == `EIF_IDX_CTRL3) begin
      d[`EIF_LVL_BIT] = lvl[1];
      d[`EIF_ES_LSB +: 2] = s.es[1];
      d[`EIF_RATE_LSB +: 2] = s.rate[1];
    end else if (idx == `EIF_IDX_STATUS) begin
      d[NCH-1:0] = s.status;
    end else if (idx == `EIF_IDX_ENABLE) begin
      d[NCH-1:0] = s.enable;
    end
    // Bits above field area stay zero
    return d;
  endfunction : eif_read

  // ==========================================================
  // Bus slave, registers, interrupt status
  always_comb begin
    logic [11:0] idx;
    logic aligned;
    logic wr_now;
    logic [1:0] clr;
    idx = AVS_ADDRESS[13:2];
    aligned = (AVS_ADDRESS[1:0] == 2'h0);
    wr_now = 1'b0;
    clr = 2'h0;
    nxt_st = st_ff;
    unique case (st_ff.bus)
      EIF_BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          nxt_st.bus = EIF_BUS_ACK;
          nxt_st.waitreq = 1'b0;
          nxt_st.rdata = 32'h0000_0000;
          if (AVS_READ && aligned) begin
            nxt_st.rdata = eif_read(st_ff, ch_lvl, idx);
          end
        end
      end
      EIF_BUS_ACK: begin
        // Write lands on the edge that sees waitrequest low
        nxt_st.bus = EIF_BUS_IDLE;
        nxt_st.waitreq = 1'b1;
        wr_now = AVS_WRITE && aligned && AVS_BYTEENABLE[0];
      end
      default: begin
        nxt_st.bus = EIF_BUS_IDLE;
        nxt_st.waitreq = 1'b1;
      end
    endcase
    if (wr_now) begin
      if (idx == `EIF_IDX_CTRL2) begin
        nxt_st.es[0] = eif_edge_t'(AVS_WRITEDATA[`EIF_ES_LSB +: 2]);
        nxt_st.rate[0] = eif_rate_t'(AVS_WRITEDATA[`EIF_RATE_LSB +: 2]);
      end else if (idx == `EIF_IDX_CTRL3) begin
        nxt_st.es[1] = eif_edge_t'(AVS_WRITEDATA[`EIF_ES_LSB +: 2]);
        nxt_st.rate[1] = eif_rate_t'(AVS_WRITEDATA[`EIF_RATE_LSB +: 2]);
      end else if (idx == `EIF_IDX_ENABLE) begin
        nxt_st.enable = AVS_WRITEDATA[NCH-1:0];
      end else if (idx == `EIF_IDX_CLEAR) begin
        clr = AVS_WRITEDATA[NCH-1:0];
      end
    end
    // New request wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~clr) | ch_req;
    nxt_st.irq = |(nxt_st.status & nxt_st.enable);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_ff.bus <= EIF_BUS_IDLE;
      st_ff.waitreq <= 1'b1;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.es[0] <= EIF_ES_RISE;
      st_ff.es[1] <= EIF_ES_RISE;
      st_ff.rate[0] <= EIF_RATE_DIV1;
      st_ff.rate[1] <= EIF_RATE_DIV1;
      st_ff.status <= `EIF_IRQ_RST;
      st_ff.enable <= `EIF_IRQ_RST;
      st_ff.irq <= 1'b0;
    end else if (CLK_EN) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign AVS_READDATA = st_ff.rdata;
  assign AVS_WAITREQUEST = st_ff.waitreq;
  assign IRQ2_REQ = ch_req[0];
  assign IRQ3_REQ = ch_req[1];
  assign IRQ = st_ff.irq;

endmodule : eif_ctrl

// ===== eif_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board logic driving the two interrupt pins
module eif_pin_model (
  input wire logic clk,
  input wire logic [1:0] drive_lvl,
  output logic pin2,
  output logic pin3
);
  always_ff @(posedge clk) begin
    pin2 <= drive_lvl[0];
    pin3 <= drive_lvl[1];
  end
endmodule : eif_pin_model

// ===== eif_ctrl_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks
module eif_ctrl_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ2_REQ,
  input wire logic IRQ3_REQ,
  input wire logic IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  chk_req2_pulse: assert property (IRQ2_REQ |=> !IRQ2_REQ) else $error("req2 wide");
  chk_req3_pulse: assert property (IRQ3_REQ |=> !IRQ3_REQ) else $error("req3 wide");
  chk_wait_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low long");
  chk_wait_answer: assert property ($rose(AVS_READ | AVS_WRITE) && CLK_EN |=> !AVS_WAITREQUEST)
    else $error("no answer");
  chk_upper_zero: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:5] == 27'h0)
    else $error("upper bits set");
  chk_data_hold: assert property (!AVS_WAITREQUEST |=> $stable(AVS_READDATA)) else $error("data moved");
  chk_reset_idle: assert property ($fell(RST) |-> AVS_WAITREQUEST && !IRQ && !IRQ2_REQ)
    else $error("not idle after reset");
  chk_irq_cause: assert property ($rose(IRQ) |-> $past(IRQ2_REQ | IRQ3_REQ | AVS_WRITE, 1)
    || $past(IRQ2_REQ | IRQ3_REQ | AVS_WRITE, 2)) else $error("irq without cause");
  cov_req2: cover property (IRQ2_REQ);
  cov_req3: cover property (IRQ3_REQ);
  cov_irq: cover property ($rose(IRQ));
endmodule : eif_ctrl_monitor

bind eif_ctrl eif_ctrl_monitor eif_ctrl_monitor_i (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ2_REQ(IRQ2_REQ), .IRQ3_REQ(IRQ3_REQ), .IRQ(IRQ));

// ===== eif_ctrl_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module eif_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic lf = 1'b0;
  logic slow = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [13:0] addr = 14'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq, irq, req2, req3, pin2, pin3;
  int bad_count = 0;
  int comparisons = 0;
  int n2 = 0;
  int n3 = 0;
  int b;
  int d [5] = '{1, 4, 8, 8, 1};
  always #50 clk = ~clk;
  always @(posedge clk) begin
    lf <= ~lf;
    if (req2 === 1'b1) n2 <= n2 + 1;
    if (req3 === 1'b1) n3 <= n3 + 1;
  end
  eif_pin_model eif_pin_model_i (.clk(clk), .drive_lvl(lvl), .pin2(pin2), .pin3(pin3));
  eif_ctrl eif_ctrl_i (.SYS_CLK(clk), .RST(rst), .CLK_EN(ce), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .EXT_IRQ2_PIN(pin2), .EXT_IRQ3_PIN(pin3), .GEAR_TICK(1'b1),
    .LOW_FREQ_TICK(lf), .LOW_SPEED_MODE(slow), .IRQ2_REQ(req2), .IRQ3_REQ(req3), .IRQ(irq));
  task automatic close_out;
    $display("counts: %0d compared, %0d failed", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] v);
    int n;
    logic late;
    n = 0;
    addr <= {idx, 2'h0};
    wdata <= {24'h0, v};
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    late = (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (late) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
      close_out();
    end
  endtask : bus
  task automatic pulse(input int ch, input int len);
    lvl[ch] <= 1'b1;
    repeat (len) @(posedge clk);
    lvl[ch] <= 1'b0;
    repeat (4 * len + 40) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 12'hfd9, 8'h0); chk(q, 32'h0);
    bus(1'b0, 12'hfda, 8'h0); chk(q, 32'h0);
    bus(1'b1, 12'hfda, 8'hff);
    bus(1'b0, 12'hfda, 8'h0); chk(q, 32'h0f);
    bus(1'b0, 12'h000, 8'h0); chk(q, 32'h0);
    $display("test registers done");
    for (int e = 0; e < 4; e++) begin
      bus(1'b1, 12'hfdc, 8'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 12'hfd9, {4'h0, e[1:0], 2'h0});
      bus(1'b1, 12'hfdd, 8'h1);
      bus(1'b1, 12'hfdc, 8'h1);
      b = n2;
      pulse(0, 20);
      chk(32'(n2 - b), (e == 2) ? 32'h2 : (e == 3) ? 32'h0 : 32'h1);
      bus(1'b0, 12'hfd9, 8'h0); chk(q, {27'h0, e == 0, e[1:0], 2'h0});
      chk({31'h0, irq}, {31'h0, e != 3});
      bus(1'b0, 12'hfdb, 8'h0); chk(q, {31'h0, e != 3});
    end
    $display("test edges done");
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 12'hfdc, 8'h0);
      bus(1'b1, 12'hfda, {4'h0, 2'h2, k[1:0]});
      slow <= (k == 3);
      repeat (48) @(posedge clk);
      bus(1'b1, 12'hfdd, 8'h2);
      bus(1'b1, 12'hfdc, 8'h2);
      b = n3;
      pulse(1, 2 * d[k]);
      chk(32'(n3 - b), 32'h0);
      b = n3;
      pulse(1, 4 * d[k] + 4);
      chk(32'(n3 - b), 32'h2);
      chk({31'h0, irq}, 32'h1);
    end
    $display("test filter done");
    // Clock enable low: a long pin pulse must leave no trace
    ce <= 1'b0;
    b = n3;
    pulse(1, 8);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(n3 - b), 32'h0);
    $display("test freeze done");
    // Reset in mid-run clears fields and the interrupt
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 12'hfda, 8'h0); chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    close_out();
  end
endmodule : eif_ctrl_bench
